// ### hw/dsmc_pkg.sv
// package: register map, field positions, reset values and state types for the drive state controller
package dsmc_pkg;
	localparam logic [11:0] DSMC_CTRL_OFS     = 12'h000;
	localparam logic [11:0] DSMC_CMD_OFS      = 12'h004;
	localparam logic [11:0] DSMC_STATUS_OFS   = 12'h008;
	localparam logic [11:0] DSMC_STATWORD_OFS = 12'h00C;
	localparam logic [11:0] DSMC_DISABLE_DECEL_OFS   = 12'h010;
	localparam logic [11:0] DSMC_QSTOP_OFS    = 12'h014;
	localparam logic [11:0] DSMC_EMTO_OFS     = 12'h018;
	localparam logic [11:0] DSMC_IN_POSITION_DELAY_OFS     = 12'h01C;
	localparam logic [11:0] DSMC_MODE_OFS     = 12'h020;
	localparam logic [11:0] DSMC_NODE_OFS     = 12'h024;
	// command bits, write-one pulses
	localparam int CMD_ENABLE   = 0;
	localparam int CMD_DISABLE  = 1;
	localparam int CMD_STOP     = 2;
	localparam int CMD_FCLR     = 3;
	localparam int CMD_CLRB5    = 4;
	localparam int CMD_LOAD     = 5;
	localparam int CMD_SAVE     = 6;
	localparam int CMD_RESTORE  = 7;
	localparam int CMD_RESET    = 8;
	localparam int CMD_POWER_ON = 9;
	localparam int CMD_POWER_OFF = 10;
	localparam int STAT_B5      = 5;
	// reset values
	localparam logic [15:0] DISABLE_DECEL_RST  = 16'h000A;
	localparam logic [15:0] QSTOP_RST   = 16'h000A;
	localparam logic [15:0] EMTO_RST    = 16'h1388;
	localparam logic [15:0] IN_POSITION_DELAY_RST    = 16'h000A;
	localparam logic [1:0]  STOPM_RST   = 2'h0;
	localparam logic [7:0]  NODE_RST    = 8'h01;
	// one delay unit = 1 ms at 250 MHz
	localparam int CLK_MHZ     = 250;
	localparam int UNIT_US     = 1000;
	localparam int UNIT_CYCLES = CLK_MHZ * UNIT_US;
	// mode codes
	localparam logic [7:0] MODE_NONE  = 8'h00;
	localparam logic [7:0] MODE_PP    = 8'h01;
	localparam logic [7:0] MODE_PV    = 8'h03;
	localparam logic [7:0] MODE_HM    = 8'h06;
	localparam logic [7:0] MODE_VEND0 = 8'hF7;
	localparam logic [7:0] MODE_POS   = 8'hFF;
	// display prefixes (ascii)
	localparam logic [7:0] PFX_NONE = 8'h20;
	localparam logic [7:0] PFX_P    = 8'h50;
	localparam logic [7:0] PFX_E    = 8'h45;
	localparam logic [7:0] PFX_F    = 8'h66;
	localparam logic [7:0] PFX_N    = 8'h6E;
	typedef enum logic [2:0] {
		ST_READY, ST_SWON, ST_OPEN, ST_STOPPING, ST_FREACT, ST_FAULT
	} dsmc_state_type;
	typedef enum logic [1:0] {NV_IDLE, NV_BUSY} dsmc_nv_type;
endpackage

// ### hw/dsmc_top.sv
// drive state and operating-mode controller with an apb register slave
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module dsmc_top
	import dsmc_pkg::*;
#(
	parameter int UNIT_CYC = UNIT_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// drive inputs
	input  wire logic        fault_in,
	input  wire logic        warning_in,
	input  wire logic        hw_enable,
	input  wire logic        motor_at_rest,
	input  wire logic        target_reached,
	input  wire logic        braked_motor,
	input  wire logic        io_mode_valid,
	input  wire logic [7:0]  io_mode,
	input  wire logic [7:0]  nv_stored_mode,
	input  wire logic        auto_homing_setting,
	input  wire logic        homing_type_setting,
	input  wire logic        nv_done,
	// drive outputs
	output logic             main_power_accept,
	output logic             motor_energy,
	output logic             brake_engage,
	output logic             motion_allow,
	output logic             decel_active,
	output logic      [15:0] decel_value,
	output logic             coast_stop,
	output logic      [7:0]  disp_prefix,
	output logic      [7:0]  disp_node,
	output logic      [7:0]  op_mode,
	output logic      [3:0]  tool_mode,
	output logic             nv_load_req,
	output logic             nv_save_req,
	output logic             nv_restore_req,
	output logic             in_position_flag
);
	dsmc_state_type state_reg;
	dsmc_nv_type    nv_reg;
	logic [1:0]  fault_stop_method;
	logic [15:0] disable_decel;
	logic [15:0] quick_stop_ramp;
	logic [15:0] emergency_timeout;
	logic [15:0] in_position_delay;
	logic [7:0]  node_reg;
	logic [15:0] statword_reg;
	logic [10:0] cmd;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic        power_on_reg;
	logic        init_reg;
	logic        mode_reject_reg;
	logic [31:0] tick_cnt;
	logic        tick;
	logic [15:0] em_cnt;
	logic [15:0] ip_cnt;
	logic        mode_ok;
	logic [7:0]  mode_req;
	logic        mode_req_v;
	logic [3:0]  tool_next;
	logic [7:0]  pwr_mode;

	// apb: zero wait states
	assign wr_en = psel && penable && pwrite;
	// read strobe in the setup cycle, so data stands through the access cycle
	assign rd_en = psel && !penable && !pwrite;
	// unmapped offsets answer with an error, writes dropped
	always_comb begin
		unique case (paddr)
			DSMC_CTRL_OFS, DSMC_CMD_OFS, DSMC_STATUS_OFS, DSMC_STATWORD_OFS, DSMC_DISABLE_DECEL_OFS,
			DSMC_QSTOP_OFS, DSMC_EMTO_OFS, DSMC_IN_POSITION_DELAY_OFS, DSMC_MODE_OFS, DSMC_NODE_OFS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign cmd = (wr_en && paddr == DSMC_CMD_OFS) ? pwdata[10:0] : 11'h000;

	// ready answers the setup cycle: one access cycle, no waits
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
		end
	end

	// configuration registers; restore returns defaults
	always_ff @(posedge clk) begin
		if (!rst_b || cmd[CMD_RESTORE] || cmd[CMD_RESET]) begin
			fault_stop_method <= STOPM_RST;
			disable_decel     <= DISABLE_DECEL_RST;
			quick_stop_ramp   <= QSTOP_RST;
			emergency_timeout <= EMTO_RST;
			in_position_delay <= IN_POSITION_DELAY_RST;
			node_reg          <= NODE_RST;
		end else if (wr_en) begin
			unique case (paddr)
				DSMC_CTRL_OFS:   fault_stop_method <= pwdata[1:0];
				DSMC_DISABLE_DECEL_OFS: disable_decel     <= pwdata[15:0];
				DSMC_QSTOP_OFS:  quick_stop_ramp   <= pwdata[15:0];
				DSMC_EMTO_OFS:   emergency_timeout <= pwdata[15:0];
				DSMC_IN_POSITION_DELAY_OFS:   in_position_delay <= pwdata[15:0];
				DSMC_NODE_OFS:   node_reg          <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// status word: events set bits, bit 5 clears alone; set wins over clear
	always_ff @(posedge clk) begin
		// drive reset also forgets recorded events
		if (!rst_b || cmd[CMD_RESET]) begin
			statword_reg <= 16'h0000;
		end else begin
			for (int i = 0; i < 16; i++) begin
				if (i == STAT_B5 && cmd[CMD_CLRB5])
					statword_reg[i] <= 1'b0;
			end
			if (fault_in)
				statword_reg[0] <= 1'b1;
			if (warning_in)
				statword_reg[1] <= 1'b1;
			if (state_reg == ST_FREACT && em_cnt == 16'h0000)
				statword_reg[STAT_B5] <= 1'b1;
			if (mode_reject_reg)
				statword_reg[2] <= 1'b1;
		end
	end

	// millisecond tick for timeout and in-position delay
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'b0;
		end else begin
			tick     <= tick_cnt == 32'(UNIT_CYC - 1);
			tick_cnt <= (tick_cnt == 32'(UNIT_CYC - 1)) ? 32'h00000000 : tick_cnt + 32'h00000001;
		end
	end

	// main power flag, set by command
	always_ff @(posedge clk) begin
		if (!rst_b || cmd[CMD_RESET])
			power_on_reg <= 1'b0;
		else if (cmd[CMD_POWER_ON])
			power_on_reg <= 1'b1;
		else if (cmd[CMD_POWER_OFF])
			power_on_reg <= 1'b0;
	end

	// drive state machine
	always_ff @(posedge clk) begin
		if (!rst_b || cmd[CMD_RESET]) begin
			state_reg <= ST_READY;
			em_cnt    <= 16'h0000;
		end else begin
			unique case (state_reg)
				ST_READY:
					if (fault_in) state_reg <= ST_FAULT;
					else if (power_on_reg) state_reg <= ST_SWON;
				// enable needs the hardware input too
				ST_SWON:
					if (fault_in) state_reg <= ST_FAULT;
					else if (!power_on_reg) state_reg <= ST_READY;
					else if (cmd[CMD_ENABLE] && hw_enable) state_reg <= ST_OPEN;
				ST_OPEN:
					if (fault_in) begin
						state_reg <= ST_FREACT;
						em_cnt    <= emergency_timeout;
					end else if (cmd[CMD_STOP] || cmd[CMD_DISABLE] || !hw_enable)
						state_reg <= ST_STOPPING;
				ST_STOPPING:
					if (fault_in) begin
						state_reg <= ST_FREACT;
						em_cnt    <= emergency_timeout;
					end else if (motor_at_rest)
						state_reg <= ST_SWON;
				ST_FREACT: begin
					if (tick && em_cnt != 16'h0000)
						em_cnt <= em_cnt - 16'h0001;
					// timeout caps the stop: cannot hang in reaction if the motor never rests
					if (motor_at_rest || em_cnt == 16'h0000)
						state_reg <= ST_FAULT;
				end
				// a clear while the fault persists is ignored
				ST_FAULT:
					if (cmd[CMD_FCLR] && !fault_in)
						state_reg <= ST_READY;
			endcase
		end
	end

	// output decode per state, all registered
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			main_power_accept <= 1'b0;
			motor_energy      <= 1'b0;
			brake_engage      <= 1'b1;
			motion_allow      <= 1'b0;
			decel_active      <= 1'b0;
			decel_value       <= 16'h0000;
			coast_stop        <= 1'b0;
			disp_prefix       <= PFX_NONE;
			disp_node         <= NODE_RST;
		end else begin
			disp_node         <= node_reg;
			main_power_accept <= state_reg == ST_READY;
			motor_energy      <= state_reg == ST_OPEN || state_reg == ST_STOPPING ||
				(state_reg == ST_FREACT && fault_stop_method != 2'h0);
			brake_engage      <= braked_motor && !(state_reg == ST_OPEN || state_reg == ST_STOPPING ||
				state_reg == ST_FREACT);
			motion_allow      <= state_reg == ST_OPEN;
			decel_active      <= state_reg == ST_STOPPING || state_reg == ST_FREACT;
			decel_value       <= (state_reg == ST_FREACT) ? quick_stop_ramp : disable_decel;
			coast_stop        <= state_reg == ST_FREACT && fault_stop_method == 2'h0;
			unique case (state_reg)
				ST_READY:              disp_prefix <= PFX_NONE;
				ST_SWON:               disp_prefix <= warning_in ? PFX_N : PFX_P;
				ST_OPEN, ST_STOPPING:  disp_prefix <= warning_in ? PFX_N : PFX_E;
				ST_FREACT, ST_FAULT:   disp_prefix <= PFX_F;
			endcase
		end
	end

	// in-position flag after delay
	// drops at once when the target is lost
	always_ff @(posedge clk) begin
		if (!rst_b || !target_reached) begin
			ip_cnt           <= 16'h0000;
			in_position_flag <= 1'b0;
		end else if (ip_cnt >= in_position_delay) begin
			in_position_flag <= 1'b1;
		end else if (tick) begin
			ip_cnt <= ip_cnt + 16'h0001;
		end
	end

	// stored mode overridden to homing when auto homing set
	always_comb begin
		if (!auto_homing_setting)
			pwr_mode = nv_stored_mode;
		else if (homing_type_setting)
			pwr_mode = MODE_HM;
		else
			pwr_mode = 8'hF9;
	end

	// mode request: io path has precedence over bus writes
	assign mode_req_v = io_mode_valid || (wr_en && paddr == DSMC_MODE_OFS);
	// power-up choice goes through the same legality check as later requests
	assign mode_req   = init_reg ? pwr_mode : (io_mode_valid ? io_mode : pwdata[7:0]);
	always_comb begin
		mode_ok = (mode_req == MODE_NONE) || (mode_req == MODE_PP) || (mode_req == MODE_PV) ||
			(mode_req == MODE_HM) || (mode_req >= MODE_VEND0);
		unique case (mode_req)
			8'hF7:   tool_next = 4'h4;
			8'hFB:   tool_next = 4'h3;
			8'hFC:   tool_next = 4'h1;
			8'hFD:   tool_next = 4'h2;
			8'hFE:   tool_next = 4'h0;
			8'hFF:   tool_next = 4'h8;
			default: tool_next = 4'hF;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			op_mode         <= MODE_NONE;
			tool_mode       <= 4'hF;
			init_reg        <= 1'b1;
			mode_reject_reg <= 1'b0;
		end else begin
			mode_reject_reg <= 1'b0;
			if (init_reg) begin
				init_reg <= 1'b0;
				// a corrupt stored mode leaves no mode rather than an undecodable one
				if (mode_ok) begin
					op_mode   <= mode_req;
					tool_mode <= tool_next;
				end else
					mode_reject_reg <= 1'b1;
			end else if (mode_req_v) begin
				if (mode_ok) begin
					op_mode   <= mode_req;
					tool_mode <= tool_next;
				end else
					mode_reject_reg <= 1'b1;
			end
		end
	end

	// non-volatile memory requests held until done
	// one request at a time: load beats save beats restore
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			nv_reg         <= NV_IDLE;
			nv_load_req    <= 1'b0;
			nv_save_req    <= 1'b0;
			nv_restore_req <= 1'b0;
		end else begin
			unique case (nv_reg)
				NV_IDLE:
					if (cmd[CMD_LOAD] || cmd[CMD_SAVE] || cmd[CMD_RESTORE]) begin
						nv_reg         <= NV_BUSY;
						nv_load_req    <= cmd[CMD_LOAD];
						nv_save_req    <= cmd[CMD_SAVE] && !cmd[CMD_LOAD];
						nv_restore_req <= cmd[CMD_RESTORE] && !cmd[CMD_LOAD] && !cmd[CMD_SAVE];
					end
				NV_BUSY:
					if (nv_done) begin
						nv_reg         <= NV_IDLE;
						nv_load_req    <= 1'b0;
						nv_save_req    <= 1'b0;
						nv_restore_req <= 1'b0;
					end
				default: nv_reg <= NV_IDLE;
			endcase
		end
	end

	// read mux
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata <= 32'h00000000;
		end else if (rd_en) begin
			unique case (paddr)
				DSMC_CTRL_OFS:     prdata <= {30'h0, fault_stop_method};
				DSMC_STATUS_OFS:   prdata <= {23'h0, nv_reg == NV_BUSY, in_position_flag, warning_in, fault_in,
					hw_enable, power_on_reg, 3'(state_reg)};
				DSMC_STATWORD_OFS: prdata <= {16'h0, statword_reg};
				DSMC_DISABLE_DECEL_OFS:   prdata <= {16'h0, disable_decel};
				DSMC_QSTOP_OFS:    prdata <= {16'h0, quick_stop_ramp};
				DSMC_EMTO_OFS:     prdata <= {16'h0, emergency_timeout};
				DSMC_IN_POSITION_DELAY_OFS:     prdata <= {16'h0, in_position_delay};
				DSMC_MODE_OFS:     prdata <= {20'h0, tool_mode, op_mode};
				DSMC_NODE_OFS:     prdata <= {24'h0, node_reg};
				default:           prdata <= 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### sim/dsmc_props.sv
// checker: port-level properties of the drive state controller
`timescale 1ns/10ps
`default_nettype none
module dsmc_props
	import dsmc_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_b,
	// apb
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	// drive side
	input wire logic       main_power_accept,
	input wire logic       motor_energy,
	input wire logic       brake_engage,
	input wire logic       braked_motor,
	input wire logic       motion_allow,
	input wire logic       decel_active,
	input wire logic       coast_stop,
	input wire logic [7:0] disp_prefix,
	input wire logic [7:0] op_mode,
	input wire logic [3:0] tool_mode,
	input wire logic       nv_load_req,
	input wire logic       nv_save_req,
	input wire logic       nv_restore_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_ready_quiet: assert property (main_power_accept |-> !motor_energy && !motion_allow) else $error("ready moves");
	a_swon_quiet: assert property (disp_prefix == PFX_P |-> !motor_energy && !motion_allow) else $error("P moves");
	a_run_brake: assert property (disp_prefix == PFX_E && braked_motor |-> motor_energy && !brake_engage)
		else $error("enabled without energy");
	a_fault_safe: assert property (disp_prefix == PFX_F && !decel_active && braked_motor |->
		!motor_energy && brake_engage) else $error("fault not safe");
	a_coast_free: assert property (coast_stop |-> !motor_energy && decel_active) else $error("coast energised");
	a_nv_single: assert property ($onehot0({nv_load_req, nv_save_req, nv_restore_req})) else $error("nv overlap");
	a_apb_ready: assert property (psel && penable |-> pready) else $error("no ready");
	a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
	a_mode_legal: assert property (op_mode inside {8'h00, 8'h01, 8'h03, 8'h06, [8'hF7:8'hFF]})
		else $error("illegal mode");
	a_tool_pos: assert property (op_mode == MODE_POS |-> tool_mode == 4'h8) else $error("tool pos");
	a_tool_none: assert property (op_mode < 8'hF7 |-> tool_mode == 4'hF) else $error("tool none");
endmodule
bind dsmc_top dsmc_props u_props (.*);
`default_nettype wire

// ### sim/dsmc_plant.sv
// partner: motor mechanics and parameter memory behind the controller
`timescale 1ns/10ps
`default_nettype none
module dsmc_plant (
	// clock
	input wire logic clk,
	// from controller and bench
	input wire logic nv_req,
	input wire logic motor_energy,
	input wire logic decel_active,
	input wire logic hold,
	// to controller
	output logic     nv_done,
	output logic     motor_at_rest
);
	logic [3:0] nv_cnt = 4'h0;
	logic [3:0] rest_cnt = 4'h0;
	// memory answers late, one pulse per request
	always @(posedge clk) begin
		nv_cnt <= (nv_req && !nv_done) ? nv_cnt + 4'h1 : 4'h0;
		nv_done <= nv_req && nv_cnt == 4'h3;
	end
	// a spinning rotor never settles at once; hold models a stuck stop
	always @(posedge clk) begin
		if ((motor_energy && !decel_active) || hold)
			rest_cnt <= 4'h0;
		else if (rest_cnt != 4'h6)
			rest_cnt <= rest_cnt + 4'h1;
	end
	assign motor_at_rest = rest_cnt == 4'h6;
endmodule
`default_nettype wire

// ### sim/tb_drive_state_mode_control.sv
// testbench: bus and state scenarios for the drive state controller
`timescale 1ns/10ps
`default_nettype none
module tb_drive_state_mode_control
	import dsmc_pkg::*;
;
	logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat, lfsr = 32'h5161;
	logic        pready, pslverr, rerr, nv_done, motor_at_rest, decel_active, coast_stop;
	logic        fault_in = 1'b0, warning_in = 1'b0, hw_enable = 1'b0, io_mode_valid = 1'b0, hold = 1'b0;
	logic        target_reached = 1'b0;
	logic        main_power_accept, motor_energy, brake_engage, motion_allow, in_position_flag;
	logic        nv_load_req, nv_save_req, nv_restore_req;
	logic [15:0] decel_value;
	logic [7:0]  io_mode = 8'h00, disp_prefix, disp_node, op_mode, m_mode = 8'h00, v;
	logic [3:0]  tool_mode;
	logic [7:0]  codes [16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'hF6,
		8'hF7, 8'hF8, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF, 8'h00};
	int          mismatches = 0, samples_checked = 0, cyc = 0, i;

	always #2 clk = ~clk;
	dsmc_top #(.UNIT_CYC(4)) DUT (.*, .braked_motor(1'b1), .nv_stored_mode(8'h00),
		.auto_homing_setting(1'b0), .homing_type_setting(1'b0));
	dsmc_plant u_plant (.clk(clk), .nv_req(nv_load_req | nv_save_req | nv_restore_req),
		.motor_energy(motor_energy), .decel_active(decel_active), .hold(hold), .nv_done(nv_done),
		.motor_at_rest(motor_at_rest));

	function automatic logic [3:0] tool_of(input logic [7:0] m);
		case (m)
			8'hF7: return 4'h4;
			8'hFB: return 4'h3;
			8'hFC: return 4'h1;
			8'hFD: return 4'h2;
			8'hFE: return 4'h0;
			8'hFF: return 4'h8;
			default: return 4'hF;
		endcase
	endfunction
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (mismatches == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic cmd(input int b);
		apb(1'b1, DSMC_CMD_OFS, 32'h1 << b);
	endtask
	// polls status until the masked field settles, bounded
	task automatic wait_stat(input logic [31:0] m, input logic [31:0] s);
		for (int n = 0; n < 40; n++) begin
			rd(DSMC_STATUS_OFS);
			if ((rdat & m) === s)
				break;
		end
		chk(rdat & m, s);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rd(DSMC_DISABLE_DECEL_OFS);
		chk(rdat, 32'hA);
		rd(DSMC_QSTOP_OFS);
		chk(rdat, 32'hA);
		rd(DSMC_EMTO_OFS);
		chk(rdat, 32'h1388);
		rd(DSMC_IN_POSITION_DELAY_OFS);
		chk(rdat, 32'hA);
		chk(op_mode, 8'h00);
		wait_stat(32'h7, 32'h0);
		chk(main_power_accept, 1'b1);
		chk(disp_prefix, PFX_NONE);
		apb(1'b1, DSMC_IN_POSITION_DELAY_OFS, 32'h2);
		target_reached <= 1'b1;
		repeat (2) @(posedge clk);
		chk(in_position_flag, 1'b0);
		wait_stat(32'h80, 32'h80);
		chk(in_position_flag, 1'b1);
		target_reached <= 1'b0;
		repeat (2) @(posedge clk);
		chk(in_position_flag, 1'b0);
		rd(12'h0FC);
		chk(rerr, 1'b1);
		chk(rdat, 32'h0);
		// every third request goes over io, the rest over the bus; model keeps the last legal code
		for (i = 0; i < 24; i++) begin
			v = i < 16 ? codes[i] : lfsr[7:0];
			lfsr = lfsr_next(lfsr);
			if (i % 3 == 2) begin
				io_mode <= v;
				io_mode_valid <= 1'b1;
				@(posedge clk);
				io_mode_valid <= 1'b0;
			end else
				apb(1'b1, DSMC_MODE_OFS, {24'h0, v});
			if (v inside {8'h00, 8'h01, 8'h03, 8'h06} || v >= 8'hF7)
				m_mode = v;
			rd(DSMC_MODE_OFS);
			chk(rdat[11:0], {tool_of(m_mode), m_mode});
			chk(op_mode, m_mode);
		end
		cmd(CMD_POWER_ON);
		wait_stat(32'h17, 32'h1);
		chk(disp_prefix, PFX_P);
		cmd(CMD_ENABLE);
		wait_stat(32'h7, 32'h1);
		hw_enable <= 1'b1;
		cmd(CMD_ENABLE);
		wait_stat(32'h17, 32'h12);
		chk({motor_energy, brake_engage, motion_allow, disp_prefix}, {3'b101, PFX_E});
		warning_in <= 1'b1;
		repeat (3) @(posedge clk);
		chk({motor_energy, disp_prefix}, {1'b1, PFX_N});
		warning_in <= 1'b0;
		apb(1'b1, DSMC_DISABLE_DECEL_OFS, 32'h22);
		cmd(CMD_DISABLE);
		repeat (2) @(posedge clk);
		chk(decel_value, 16'h0022);
		wait_stat(32'h7, 32'h1);
		cmd(CMD_ENABLE);
		wait_stat(32'h7, 32'h2);
		cmd(CMD_STOP);
		wait_stat(32'h7, 32'h1);
		// stuck rotor: only the emergency time ends the reaction
		cmd(CMD_ENABLE);
		apb(1'b1, DSMC_EMTO_OFS, 32'h2);
		hold <= 1'b1;
		fault_in <= 1'b1;
		repeat (3) @(posedge clk);
		chk({coast_stop, decel_active, motor_energy, decel_value}, {3'b110, QSTOP_RST});
		wait_stat(32'h7, 32'h5);
		chk({motor_energy, brake_engage, disp_prefix}, {2'b01, PFX_F});
		rd(DSMC_STATWORD_OFS);
		chk(rdat[5:0], 6'h27);
		cmd(CMD_CLRB5);
		rd(DSMC_STATWORD_OFS);
		chk(rdat[5:0], 6'h07);
		cmd(CMD_FCLR);
		wait_stat(32'h7, 32'h5);
		fault_in <= 1'b0;
		hold <= 1'b0;
		cmd(CMD_POWER_OFF);
		cmd(CMD_FCLR);
		wait_stat(32'hF, 32'h0);
		apb(1'b1, DSMC_DISABLE_DECEL_OFS, 32'h33);
		for (i = CMD_LOAD; i <= CMD_RESTORE; i++) begin
			cmd(i);
			@(posedge clk);
			chk({nv_restore_req, nv_save_req, nv_load_req}, 32'h1 << (i - CMD_LOAD));
			wait_stat(32'h100, 32'h0);
		end
		rd(DSMC_DISABLE_DECEL_OFS);
		chk(rdat, 32'hA);
		cmd(CMD_POWER_ON);
		wait_stat(32'hF, 32'h9);
		apb(1'b1, DSMC_NODE_OFS, 32'h5A);
		repeat (2) @(posedge clk);
		chk(disp_node, 8'h5A);
		cmd(CMD_RESET);
		wait_stat(32'hF, 32'h0);
		rd(DSMC_NODE_OFS);
		chk(rdat, {24'h0, NODE_RST});
		stop_test();
	end
endmodule
`default_nettype wire
